// *** verilog/system_watchdog_timer.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Watchdog runs enabled straight after reset
// - Disable instruction stops counting, not the reset request after a prewarning; enable instruction resumes
// - Overflow gives prewarning, then reset request
// - 16-bit counter, prescaler 16384 or 256
// - Counter loads from programmable reload value
// - Service reloads counter and clears prescaler, before a prewarning only
// - Reset defaults give 6.5 ms at 10 MHz
module system_watchdog_timer #(
	parameter int SLOW_DIVIDE    = watchdog_pkg::SLOW_DIVIDE,
	parameter int FAST_DIVIDE    = watchdog_pkg::FAST_DIVIDE,
	parameter int PREWARN_CYCLES = watchdog_pkg::PREWARN_CYCLES
) (
	input  wire logic                             ref_clk,
	input  wire logic                             rst_n,
	input  wire watchdog_pkg::core_command_type   command,
	output      watchdog_pkg::watchdog_status_type status
);
	import watchdog_pkg::*;

	localparam logic [WARN_WIDTH-1:0] WARN_START = WARN_WIDTH'(PREWARN_CYCLES - 1);
	localparam logic [WARN_WIDTH-1:0] WARN_ZERO  = '0;
	localparam logic [WARN_WIDTH-1:0] WARN_ONE   = WARN_WIDTH'(1);

	// ****************************************************************
	// State
	// ****************************************************************
	watchdog_state_type     state;
	watchdog_state_type     next_state;
	logic                   enabled;
	logic [COUNT_WIDTH-1:0] count;
	logic [COUNT_WIDTH-1:0] reload;
	logic                   slow_select;
	logic [WARN_WIDTH-1:0]  warn_count;
	logic                   prewarning_irq;
	logic                   reset_request;
	logic                   tick;

	// ****************************************************************
	// Next values
	// ****************************************************************
	logic                   next_enabled;
	logic [COUNT_WIDTH-1:0] next_count;
	logic [COUNT_WIDTH-1:0] count_up;
	logic [COUNT_WIDTH-1:0] next_reload;
	logic                   next_slow_select;
	logic [WARN_WIDTH-1:0]  next_warn_count;
	logic                   next_prewarning_irq;
	logic                   next_reset_request;
	logic                   reload_now;
	logic                   warn_running;

	// ****************************************************************
	// Decode
	// ****************************************************************
	wire in_counting  = (state == counting);
	wire prescale_run = enabled && in_counting;
	wire service_now  = command.service && in_counting;
	wire overflow     = tick && (count == COUNT_ALL_ONES);
	wire warn_done    = (state == prewarning) && (warn_count == WARN_ZERO);

	assign reload_now   = service_now || overflow;
	assign warn_running = (warn_count != WARN_ZERO);

	// ****************************************************************
	// Selection; a service in the overflow cycle wins, since software
	// did meet the deadline
	// ****************************************************************
	assign next_enabled = command.watchdog_enable_instruction ? 1'b1 :
	                      command.watchdog_disable_instruction ? 1'b0 : enabled;

	assign next_reload = command.reload_write ? command.watchdog_reload_value :
	                     reload;

	assign next_slow_select = command.prescale_write ? command.prescale_slow :
	                          slow_select;

	assign count_up   = count + COUNT_ONE;
	assign next_count = reload_now ? reload :
	                    (tick ? count_up : count);

	assign next_warn_count = in_counting  ? WARN_START :
	                         warn_running ? warn_count - WARN_ONE :
	                         warn_count;

	assign next_prewarning_irq = in_counting && (next_state == prewarning);
	assign next_reset_request  = reset_request || warn_done;

	// ****************************************************************
	// Failure sequence
	// ****************************************************************
	always_comb begin
		next_state = state;
		case (state)
			counting: begin
				if (overflow && !service_now) begin
					next_state = prewarning;
				end
			end
			prewarning: begin
				if (warn_done) begin
					next_state = failed;
				end
			end
			failed: begin
				next_state = failed;
			end
			default: begin
				next_state = counting;
			end
		endcase
	end

	// ****************************************************************
	// Prescaler
	// ****************************************************************
	watchdog_prescaler #(
		.SLOW_DIVIDE (SLOW_DIVIDE),
		.FAST_DIVIDE (FAST_DIVIDE)
	) watchdog_prescaler_i (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.run         (prescale_run),
		.clear       (service_now),
		.slow_select (slow_select),
		.tick        (tick)
	);

	// ****************************************************************
	// Enable; enable wins when both strobes arrive together
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enabled <= ENABLE_DEFAULT;
		end else begin
			enabled <= next_enabled;
		end
	end

	// ****************************************************************
	// Reload value; a new value applies from the next reload only
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reload <= RELOAD_DEFAULT;
		end else begin
			reload <= next_reload;
		end
	end

	// ****************************************************************
	// Ratio request; the prescaler takes it only at a restart
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_select <= SLOW_SELECT_DEFAULT;
		end else begin
			slow_select <= next_slow_select;
		end
	end

	// ****************************************************************
	// Counter
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= RELOAD_DEFAULT;
		end else begin
			count <= next_count;
		end
	end

	// ****************************************************************
	// Failure response; once warned, a service cannot stop the reset,
	// the failed software is not trusted to recover
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= counting;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Gap counter between prewarning and reset request
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			warn_count <= WARN_ZERO;
		end else begin
			warn_count <= next_warn_count;
		end
	end

	// ****************************************************************
	// Prewarning pulse, one cycle
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prewarning_irq <= 1'b0;
		end else begin
			prewarning_irq <= next_prewarning_irq;
		end
	end

	// ****************************************************************
	// Reset request; sticky until rst_n, so a glitch cannot drop it
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_request <= 1'b0;
		end else begin
			reset_request <= next_reset_request;
		end
	end

	// ****************************************************************
	// Status outputs
	// ****************************************************************

	assign status.prewarning_irq = prewarning_irq;
	assign status.reset_request  = reset_request;
	assign status.running        = enabled;
	assign status.count          = count;

endmodule : system_watchdog_timer

// *** verilog/watchdog_pkg.sv ***
package watchdog_pkg;

	// ****************************************************************
	// Counter and prescaler layout
	// ****************************************************************
	localparam int          COUNT_WIDTH     = 16;
	localparam int          PRESCALE_WIDTH  = 14;
	localparam int          SLOW_DIVIDE     = 16384;
	localparam int          FAST_DIVIDE     = 256;
	localparam logic [15:0] COUNT_ALL_ONES  = 16'hffff;
	localparam logic [15:0] COUNT_ONE       = 16'h0001;

	// ****************************************************************
	// Reset defaults: 256 ticks of 25.6 us at 10 MHz give about 6.5 ms
	// ****************************************************************
	localparam logic [15:0] RELOAD_DEFAULT     = 16'hff00;
	localparam logic        SLOW_SELECT_DEFAULT = 1'b0;
	localparam logic        ENABLE_DEFAULT     = 1'b1;

	// ****************************************************************
	// Gap between prewarning and reset request
	// ****************************************************************
	localparam int          PREWARN_CYCLES  = 16;
	localparam int          WARN_WIDTH      = 8;

	// Core instruction strobes, one cycle each
	typedef struct packed {
		logic        watchdog_disable_instruction;
		logic        watchdog_enable_instruction;
		logic        service;
		logic        reload_write;
		logic        prescale_write;
		logic        prescale_slow;
		logic [15:0] watchdog_reload_value;
	} core_command_type;

	typedef struct packed {
		logic        prewarning_irq;
		logic        reset_request;
		logic        running;
		logic [15:0] count;
	} watchdog_status_type;

	typedef enum logic [1:0] {
		counting,
		prewarning,
		failed
	} watchdog_state_type;

endpackage : watchdog_pkg

// *** verilog/watchdog_prescaler.sv ***
`timescale 1ns/1ps
module watchdog_prescaler #(
	parameter int SLOW_DIVIDE = watchdog_pkg::SLOW_DIVIDE,
	parameter int FAST_DIVIDE = watchdog_pkg::FAST_DIVIDE
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic run,
	input  wire logic clear,
	input  wire logic slow_select,
	output      logic tick
);
	import watchdog_pkg::*;

	localparam logic [PRESCALE_WIDTH-1:0] SLOW_LAST = PRESCALE_WIDTH'(SLOW_DIVIDE - 1);
	localparam logic [PRESCALE_WIDTH-1:0] FAST_LAST = PRESCALE_WIDTH'(FAST_DIVIDE - 1);
	localparam logic [PRESCALE_WIDTH-1:0] ZERO      = '0;
	localparam logic [PRESCALE_WIDTH-1:0] ONE       = PRESCALE_WIDTH'(1);

	logic [PRESCALE_WIDTH-1:0] count;
	logic                      ratio_slow;
	wire  [PRESCALE_WIDTH-1:0] last_value = ratio_slow ? SLOW_LAST : FAST_LAST;
	wire                       wrap       = run && (count == last_value);
	wire                       restart    = clear || wrap;

	assign tick = wrap && !clear;

	// ****************************************************************
	// Ratio is latched only at a restart, so a change never cuts a
	// running period short
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count      <= ZERO;
			ratio_slow <= SLOW_SELECT_DEFAULT;
		end else if (restart) begin
			count      <= ZERO;
			ratio_slow <= slow_select;
		end else if (run) begin
			count <= count + ONE;
		end
	end

endmodule : watchdog_prescaler

// *** verification/system_watchdog_timer_monitor.sv ***
`timescale 1ns/1ps
module system_watchdog_timer_monitor #(
	parameter int PREWARN_CYCLES = 16
) (
	input wire logic                              ref_clk,
	input wire logic                              rst_n,
	input wire watchdog_pkg::core_command_type    command,
	input wire watchdog_pkg::watchdog_status_type status
);
	import watchdog_pkg::*;
	// ****
	// Shadow of the stored reload value
	// ****
	localparam int W_LO = PREWARN_CYCLES;
	localparam int W_HI = PREWARN_CYCLES + 2;
	logic [15:0] reload;
	logic        in_warn;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reload  <= RELOAD_DEFAULT;
			in_warn <= 1'b0;
		end else begin
			if (command.reload_write) reload <= command.watchdog_reload_value;
			if (status.prewarning_irq) in_warn <= 1'b1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_reset_armed: assert property ($rose(rst_n) |-> status.running && status.count == RELOAD_DEFAULT)
		else $error("not armed after reset");
	a_disable_stops: assert property (command.watchdog_disable_instruction && !command.watchdog_enable_instruction |=> !status.running)
		else $error("disable ignored");
	a_enable_runs: assert property (command.watchdog_enable_instruction |=> status.running)
		else $error("enable ignored");
	a_stopped_holds: assert property (!status.running && !command.service && !command.watchdog_enable_instruction |=> $stable(status.count))
		else $error("count moved while stopped");
	a_service_load: assert property (command.service && status.running && !in_warn && !status.prewarning_irq |=> status.count == reload)
		else $error("service did not reload");
	a_count_step: assert property ($changed(status.count) |-> status.count == $past(status.count) + 16'h0001 || status.count == reload)
		else $error("count step wrong");
	a_warn_cause: assert property (status.prewarning_irq |-> $past(status.count) == COUNT_ALL_ONES && status.count == reload)
		else $error("prewarning without wrap");
	a_warn_then_reset: assert property ($rose(status.prewarning_irq) |-> ##[W_LO:W_HI] status.reset_request)
		else $error("no reset request after prewarning");
	a_reset_cause: assert property ($rose(status.reset_request) |-> in_warn)
		else $error("reset request without prewarning");
endmodule : system_watchdog_timer_monitor

bind system_watchdog_timer system_watchdog_timer_monitor #(.PREWARN_CYCLES(PREWARN_CYCLES)) mon_i (
	.ref_clk(ref_clk), .rst_n(rst_n), .command(command), .status(status));

// *** verification/core_model.sv ***
`timescale 1ns/1ps
module core_model (
	input  wire logic                     ref_clk,
	output watchdog_pkg::core_command_type command
);
	import watchdog_pkg::*;
	initial command = '0;
	// Each instruction is a one-cycle strobe; the core services in time or lets it lapse
	task automatic send(input core_command_type c);
		@(negedge ref_clk) command = c;
		@(negedge ref_clk) command = '0;
	endtask : send
endmodule : core_model

// *** verification/system_watchdog_timer_test.sv ***
`timescale 1ns/1ps
module system_watchdog_timer_test;
	import watchdog_pkg::*;
	logic                ref_clk = 1'b0;
	logic                rst_n   = 1'b0;
	core_command_type    command;
	watchdog_status_type status;
	int                  n_errors = 0;
	int                  cmp_count = 0;
	int                  seed = 31593;
	logic [15:0]         exp_q[$];
	always #5 ref_clk = ~ref_clk;
	core_model core_model_i (.ref_clk(ref_clk), .command(command));
	// Short divides keep the run brief
	system_watchdog_timer #(.SLOW_DIVIDE(64), .FAST_DIVIDE(8), .PREWARN_CYCLES(16))
		system_watchdog_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .command(command), .status(status));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	always @(negedge ref_clk) if (status.prewarning_irq === 1'b1) chk("warn_count", exp_q.pop_front(), status.count);
	initial begin
		#50us;
		n_errors++;
		report_and_stop();
	end
	initial begin
		core_command_type c;
		logic [15:0]      rel;
		logic [15:0]      v;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk) rst_n = 1'b1;
		@(negedge ref_clk);
		chk("running", 16'h0001, {15'h0, status.running});
		chk("count", 16'hff00, status.count);
		rel = 16'hffe0 | (16'($random(seed)) & 16'h000f);
		c = '0; c.reload_write = 1'b1; c.watchdog_reload_value = rel;
		core_model_i.send(c);
		c = '0; c.service = 1'b1;
		core_model_i.send(c);
		chk("service", rel, status.count);
		c = '0; c.watchdog_disable_instruction = 1'b1;
		core_model_i.send(c);
		v = status.count;
		repeat (40) @(negedge ref_clk);
		chk("held", v, status.count);
		chk("stopped", 16'h0000, {15'h0, status.running});
		c = '0; c.watchdog_enable_instruction = 1'b1;
		core_model_i.send(c);
		chk("resumed", 16'h0001, {15'h0, status.running});
		c = '0; c.prescale_write = 1'b1; c.prescale_slow = 1'b1;
		core_model_i.send(c);
		c = '0; c.service = 1'b1;
		core_model_i.send(c);
		repeat (60) @(negedge ref_clk);
		chk("slow_hold", rel, status.count);
		repeat (10) @(negedge ref_clk);
		chk("slow_tick", rel + 16'h0001, status.count);
		c = '0; c.prescale_write = 1'b1;
		core_model_i.send(c);
		c = '0; c.service = 1'b1;
		exp_q.push_back(rel);
		core_model_i.send(c);
		for (int i = 0; i < 2000 && status.reset_request !== 1'b1; i++) @(negedge ref_clk);
		chk("reset_request", 16'h0001, {15'h0, status.reset_request});
		chk("warn_seen", 16'h0000, 16'(exp_q.size()));
		report_and_stop();
	end
endmodule : system_watchdog_timer_test
